// [src/nand_ecc_consts.svh]
// offsets, field positions, reset values and page geometry of the nand ecc unit
`ifndef NAND_ECC_CONSTS_SVH
`define NAND_ECC_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define ECC_CONTROL_OFS 8'h00
`define ECC_MODE_OFS 8'h04
`define ECC_STATUS_OFS 8'h08
`define ECC_PARITY_OFS 8'h0c
`define ECC_INVERTED_PARITY_OFS 8'h10
`define ECC_STORED_CODE_OFS 8'h20
`define ECC_INT_STATUS_OFS 8'h24
`define ECC_INT_MASK_OFS 8'h28
`define ECC_WIDTH_OFS 8'h2c

// ****************************************
// field positions
// ****************************************
`define CTL_CLEAR_BIT 0
`define MODE_SEL_LSB 0
`define STAT_ANY_BIT 0
`define STAT_CODE_BIT 1
`define STAT_MULTI_BIT 2
`define INT_DONE_BIT 0
`define INT_ERROR_BIT 1
`define WIDTH_16_BIT 0

// ****************************************
// reset values
// ****************************************
`define MODE_RESET 2'h0
`define INT_MASK_RESET 2'h0
`define WIDTH_RESET 1'h0

// ****************************************
// page geometry in words
// ****************************************
`define MAIN_WORDS_0 13'h0200
`define MAIN_WORDS_1 13'h0400
`define MAIN_WORDS_2 13'h0800
`define MAIN_WORDS_3 13'h1000
`define TOTAL_WORDS_0 13'h0210
`define TOTAL_WORDS_1 13'h0420
`define TOTAL_WORDS_2 13'h0840
`define TOTAL_WORDS_3 13'h1080
`define ROW_MASK_0 12'h1ff
`define ROW_MASK_1 12'h3ff
`define ROW_MASK_2 12'h7ff
`define ROW_MASK_3 12'hfff

`endif

// [src/nand_ecc_pkg.sv]
// types shared by the nand ecc unit files
package nand_ecc_pkg;
   typedef enum {ph_main, ph_spare, ph_done} page_phase_t;
   typedef logic [1:0] page_len_t;
   typedef logic [11:0] row_t;
   typedef logic [3:0] col_t;
endpackage

// [src/word_parity_fold.sv]
// per-word parity contributions for row and column terms
`timescale 1ns/1ps
module word_parity_fold
   import nand_ecc_pkg::*;
(
   // word under transfer
   input wire logic [15:0] word,
   input wire logic wide,
   input wire logic [11:0] index,
   input wire logic [11:0] row_mask,
   // contributions to the accumulators
   output row_t row_hit,
   output row_t row_miss,
   output col_t col_one,
   output col_t col_zero
);
   logic [15:0] w;
   logic wp;

   // ****************************************
   // column selection pattern
   // ****************************************
   function automatic logic [15:0] col_pattern(input int b);
      case (b)
         0: col_pattern = 16'haaaa;
         1: col_pattern = 16'hcccc;
         2: col_pattern = 16'hf0f0;
         default: col_pattern = 16'hff00;
      endcase
   endfunction

   // narrow words see only the low byte
   assign w = wide ? word : {8'h00, word[7:0]};
   assign wp = ^w;

   genvar i;
   generate
      for (i = 0; i < 12; i++) begin : g_row
         assign row_hit[i] = row_mask[i] & index[i] & wp;
         assign row_miss[i] = row_mask[i] & ~index[i] & wp;
      end
      for (i = 0; i < 4; i++) begin : g_col
         // bit 3 term exists only on 16-bit words
         if (i < 3) begin : g_low
            assign col_one[i] = ^(w & col_pattern(i));
            assign col_zero[i] = ^(w & ~col_pattern(i));
         end else begin : g_high
            assign col_one[i] = wide & ^(w & col_pattern(i));
            assign col_zero[i] = wide & ^(w & ~col_pattern(i));
         end
      end
   endgenerate
endmodule // word_parity_fold

// [src/nand_page_ecc_unit.sv]
// nand page ecc unit: parity accumulation, check and register file
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "nand_ecc_consts.svh"

module nand_page_ecc_unit
   import nand_ecc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // flash data watch
   input wire logic [15:0] flash_word,
   input wire logic flash_word_strobe,
   // interrupt
   output logic irq
);

   // ****************************************
   // state
   // ****************************************
   page_len_t page_length_sel;
   logic wide_words;
   row_t row_p;
   row_t row_pn;
   col_t col_p;
   col_t col_pn;
   logic any_error_flag;
   logic code_byte_error_flag;
   logic multi_error_flag;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic [12:0] word_count;
   page_phase_t phase;
   page_phase_t next_phase;
   row_t row_hit;
   row_t row_miss;
   col_t col_one;
   col_t col_zero;
   row_t row_mask;
   col_t col_mask;
   logic [15:0] full_mask;
   logic [15:0] syn;
   logic [15:0] syn_n;
   logic [15:0] syn_both;
   logic single_err;
   logic code_err;
   logic no_err;
   logic [1:0] int_set;
   logic [31:0] next_rdata;
   logic wr_control;
   logic wr_mode;
   logic wr_code;
   logic wr_int_status;
   logic wr_int_mask;
   logic wr_width;
   logic clear_req;
   logic take_word;

   // ****************************************
   // geometry decode
   // ****************************************
   function automatic logic [12:0] main_words(input page_len_t s);
      case (s)
         2'h0: main_words = `MAIN_WORDS_0;
         2'h1: main_words = `MAIN_WORDS_1;
         2'h2: main_words = `MAIN_WORDS_2;
         default: main_words = `MAIN_WORDS_3;
      endcase
   endfunction

   function automatic logic [12:0] total_words(input page_len_t s);
      case (s)
         2'h0: total_words = `TOTAL_WORDS_0;
         2'h1: total_words = `TOTAL_WORDS_1;
         2'h2: total_words = `TOTAL_WORDS_2;
         default: total_words = `TOTAL_WORDS_3;
      endcase
   endfunction

   function automatic row_t row_mask_of(input page_len_t s);
      case (s)
         2'h0: row_mask_of = `ROW_MASK_0;
         2'h1: row_mask_of = `ROW_MASK_1;
         2'h2: row_mask_of = `ROW_MASK_2;
         default: row_mask_of = `ROW_MASK_3;
      endcase
   endfunction

   // top row term follows the page length
   assign row_mask = row_mask_of(page_length_sel);
   assign col_mask = wide_words ? 4'hf : 4'h7;
   assign full_mask = {row_mask, col_mask};

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      wr_control = 1'b0;
      wr_mode = 1'b0;
      wr_code = 1'b0;
      wr_int_status = 1'b0;
      wr_int_mask = 1'b0;
      wr_width = 1'b0;
      if (reg_wr) begin
         if (reg_addr == `ECC_CONTROL_OFS) begin
            wr_control = 1'b1;
         end else if (reg_addr == `ECC_MODE_OFS) begin
            wr_mode = 1'b1;
         end else if (reg_addr == `ECC_STORED_CODE_OFS) begin
            wr_code = 1'b1;
         end else if (reg_addr == `ECC_INT_STATUS_OFS) begin
            wr_int_status = 1'b1;
         end else if (reg_addr == `ECC_INT_MASK_OFS) begin
            wr_int_mask = 1'b1;
         end else if (reg_addr == `ECC_WIDTH_OFS) begin
            wr_width = 1'b1;
         end
      end
   end

   // zero in the clear bit is a no-op
   assign clear_req = wr_control & reg_wdata[`CTL_CLEAR_BIT];

   // ****************************************
   // page walk
   // ****************************************
   always_comb begin
      next_phase = phase;
      case (phase)
         ph_main: begin
            if (flash_word_strobe && word_count == main_words(page_length_sel) - 13'h0001) begin
               next_phase = ph_spare;
            end
         end
         ph_spare: begin
            if (flash_word_strobe && word_count == total_words(page_length_sel) - 13'h0001) begin
               next_phase = ph_done;
            end
         end
         default: next_phase = ph_done;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst || clear_req) begin
         phase <= ph_main;
      end else begin
         phase <= next_phase;
      end
   end

   // counts words in flash units; stops at the page end
   always_ff @(posedge clock) begin
      if (sys_rst || clear_req) begin
         word_count <= 13'h0000;
      end else if (flash_word_strobe && phase != ph_done) begin
         word_count <= word_count + 13'h0001;
      end
   end

   // spare-area words carry the code and stay out of it
   assign take_word = flash_word_strobe && phase == ph_main;

   word_parity_fold u_fold (
      .word(flash_word),
      .wide(wide_words),
      .index(word_count[11:0]),
      .row_mask(row_mask),
      .row_hit(row_hit),
      .row_miss(row_miss),
      .col_one(col_one),
      .col_zero(col_zero)
   );

   // ****************************************
   // syndrome against stored code
   // ****************************************
   assign syn = ({row_p, col_p} ^ reg_wdata[15:0]) & full_mask;
   assign syn_n = ({row_pn, col_pn} ^ reg_wdata[31:16]) & full_mask;
   assign syn_both = syn | syn_n;
   assign no_err = syn_both == 16'h0000;
   // a data bit error flips every term pair exactly once
   assign single_err = (syn ^ syn_n) == full_mask;
   // a flipped code bit shows as one lone syndrome bit
   assign code_err = $countones(syn_both) == 1;

   // ****************************************
   // parity accumulators
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst || clear_req) begin
         row_p <= 12'h000;
         row_pn <= 12'h000;
         col_p <= 4'h0;
         col_pn <= 4'h0;
      end else if (wr_code) begin
         // syndrome replaces the sums: word index above, bit offset below
         row_p <= syn[15:4];
         col_p <= syn[3:0];
         row_pn <= syn_n[15:4];
         col_pn <= syn_n[3:0];
      end else if (take_word) begin
         row_p <= row_p ^ row_hit;
         row_pn <= row_pn ^ row_miss;
         col_p <= col_p ^ col_one;
         col_pn <= col_pn ^ col_zero;
      end
   end

   // ****************************************
   // error flags
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst || clear_req) begin
         any_error_flag <= 1'b0;
         code_byte_error_flag <= 1'b0;
         multi_error_flag <= 1'b0;
      end else if (wr_code) begin
         any_error_flag <= !no_err;
         code_byte_error_flag <= code_err;
         multi_error_flag <= !no_err && !single_err && !code_err;
      end
   end

   // ****************************************
   // configuration
   // ****************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         page_length_sel <= `MODE_RESET;
      end else if (wr_mode) begin
         page_length_sel <= reg_wdata[`MODE_SEL_LSB +: 2];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wide_words <= `WIDTH_RESET;
      end else if (wr_width) begin
         wide_words <= reg_wdata[`WIDTH_16_BIT];
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   assign int_set = {wr_code & !no_err, wr_code};

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         int_status <= 2'h0;
      end else begin
         int_status <= (int_status & ~(wr_int_status ? reg_wdata[1:0] : 2'h0)) | int_set;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         int_mask <= `INT_MASK_RESET;
      end else if (wr_int_mask) begin
         int_mask <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   // ****************************************
   // read path
   // ****************************************
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_addr == `ECC_MODE_OFS) begin
         next_rdata = {30'h0000_0000, page_length_sel};
      end else if (reg_addr == `ECC_STATUS_OFS) begin
         next_rdata = {29'h0000_0000, multi_error_flag, code_byte_error_flag, any_error_flag};
      end else if (reg_addr == `ECC_PARITY_OFS) begin
         next_rdata = {16'h0000, row_p, col_p};
      end else if (reg_addr == `ECC_INVERTED_PARITY_OFS) begin
         next_rdata = {16'h0000, row_pn, col_pn};
      end else if (reg_addr == `ECC_INT_STATUS_OFS) begin
         next_rdata = {30'h0000_0000, int_status};
      end else if (reg_addr == `ECC_INT_MASK_OFS) begin
         next_rdata = {30'h0000_0000, int_mask};
      end else if (reg_addr == `ECC_WIDTH_OFS) begin
         next_rdata = {31'h0000_0000, wide_words};
      end
   end

   // data only in the cycle after the read strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   clear_parity_a: assert property (clear_req |=> row_p == 12'h000 && row_pn == 12'h000
      && col_p == 4'h0 && col_pn == 4'h0)
      else $error("parity not cleared");

   ctrl_noeffect_a: assert property (wr_control && !reg_wdata[0] && !flash_word_strobe
      |=> $stable(row_p) && $stable(col_pn))
      else $error("control zero changed parity");

   mode_store_a: assert property (wr_mode |=> page_length_sel == $past(reg_wdata[1:0]))
      else $error("page length not stored");

   row_accum_a: assert property (take_word && !wr_code && !clear_req && word_count[0]
      |=> row_p[0] == ($past(row_p[0]) ^ $past(^(wide_words ? flash_word : {8'h00, flash_word[7:0]}))))
      else $error("row term wrong");

   top_row_mask_a: assert property (take_word && !wr_code && !clear_req
      |=> ((row_p ^ $past(row_p)) & ~$past(row_mask)) == 12'h000) else $error("top row overflow");

   any_err_a: assert property (multi_error_flag || code_byte_error_flag |-> any_error_flag)
      else $error("error flag without any flag");

   multi_clear_a: assert property (wr_code && no_err |=> !multi_error_flag ##0 !any_error_flag)
      else $error("multi flag on clean page");

   single_addr_a: assert property (wr_code && single_err
      |=> {row_p, col_p} == $past(syn) && !multi_error_flag)
      else $error("failing address not loaded");

   code_byte_a: assert property (code_byte_error_flag
      |-> $countones({row_p, col_p} | {row_pn, col_pn}) == 1 || $past(take_word))
      else $error("code byte error position not unique");

   word_width_a: assert property (!wide_words && !$past(wide_words) && $past(take_word)
      |-> $stable(col_p[3]))
      else $error("narrow word touched high column");

   spare_skip_a: assert property (phase != ph_main && !wr_code && !clear_req
      |=> $stable(row_p) && $stable(row_pn))
      else $error("spare word accumulated");

   irq_level_a: assert property (##1 irq == $past(|(int_status & int_mask)))
      else $error("interrupt level wrong");

endmodule // nand_page_ecc_unit

// [test/nand_flash_model.sv]
// behavioural flash part that moves page words past the ecc unit
`timescale 1ns/1ps
module nand_flash_model (
   // clock
   input wire logic clock,
   // flash data bus as the ecc unit sees it
   output logic [15:0] flash_word,
   output logic flash_word_strobe
);
   logic [15:0] mem [0:4223];
   initial begin
      flash_word = 16'h0000;
      flash_word_strobe = 1'h0;
   end
   // fixed pattern, seed picks the page
   task automatic load(input logic [15:0] seed);
      for (int i = 0; i < 4224; i++) begin
         mem[i] = 16'(i * 40503) ^ seed;
      end
   endtask
   // gap above zero inserts an idle cycle after every gap words: a slow part
   task automatic send(input int n, input logic wide, input int gap);
      for (int j = 0; j < n; j++) begin
         @(posedge clock);
         // an 8-bit part leaves the high byte undriven: show junk there
         flash_word <= wide ? mem[j] : {~mem[j][7:0], mem[j][7:0]};
         flash_word_strobe <= 1'h1;
         if (gap > 0 && j % gap == gap - 1) begin
            @(posedge clock);
            flash_word_strobe <= 1'h0;
            flash_word <= ~flash_word;
         end
      end
      @(posedge clock);
      flash_word_strobe <= 1'h0;
      flash_word <= ~flash_word;
   endtask
endmodule // nand_flash_model

// [test/testbench.sv]
// self-checking bench for the nand page ecc unit
`timescale 1ns/1ps
`include "nand_ecc_consts.svh"
module testbench;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic [15:0] flash_word;
   logic flash_word_strobe;
   logic irq;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] good;
   logic [31:0] d;
   logic [31:0] e;

   always #50 clock = ~clock;

   nand_page_ecc_unit nand_page_ecc_unit_inst (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .flash_word(flash_word),
      .flash_word_strobe(flash_word_strobe), .irq(irq));
   nand_flash_model nand_flash_model_inst (.clock(clock), .flash_word(flash_word),
      .flash_word_strobe(flash_word_strobe));

   // ******
   // bus and compare helpers
   // ******
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1;
      v = reg_rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp, what);
   endtask
   // expected {inverted, parity} over the main area now held by the part
   function automatic logic [31:0] calc(input int n, input int rows, input logic wide);
      logic [15:0] p;
      logic [15:0] np;
      logic [15:0] w;
      p = 16'h0000;
      np = 16'h0000;
      for (int j = 0; j < n; j++) begin
         w = nand_flash_model_inst.mem[j];
         if (!wide) w[15:8] = 8'h00;
         for (int i = 0; i < rows; i++) begin
            if (j[i]) p[4 + i] ^= ^w;
            else np[4 + i] ^= ^w;
         end
         p[2:0] ^= {^(w & 16'hf0f0), ^(w & 16'hcccc), ^(w & 16'haaaa)};
         np[2:0] ^= {^(w & 16'h0f0f), ^(w & 16'h3333), ^(w & 16'h5555)};
         if (wide) begin
            p[3] ^= ^(w & 16'hff00);
            np[3] ^= ^(w & 16'h00ff);
         end
      end
      return {np, p};
   endfunction
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clock);
      #1;
      chk({31'h0, irq}, {31'h0, exp}, "irq");
   endtask

   // ******
   // scenarios
   // ******
   task automatic t_reset;
      for (int a = 0; a <= 44; a += 4) rchk(8'(a), 32'h0, "reset value");
      chk({31'h0, irq}, 32'h0, "irq at reset");
   endtask
   task automatic t_mode;
      for (int m = 0; m < 4; m++) begin
         wr(`ECC_MODE_OFS, 32'hfffffff0 | m);
         rchk(`ECC_MODE_OFS, m, "mode readback");
      end
   endtask
   // every page length, slow part on the longest; spare words must not count
   task automatic t_sizes;
      wr(`ECC_WIDTH_OFS, 32'h0);
      for (int m = 0; m < 4; m++) begin
         nand_flash_model_inst.load(16'h5a3c + 16'(m));
         good = calc(512 << m, 9 + m, 1'h0);
         wr(`ECC_MODE_OFS, m);
         wr(`ECC_CONTROL_OFS, 32'h1);
         nand_flash_model_inst.send(528 << m, 1'h0, m == 3 ? 7 : 0);
         rchk(`ECC_PARITY_OFS, good[15:0], "parity");
         rchk(`ECC_INVERTED_PARITY_OFS, good[31:16], "inverted parity");
      end
      wr(`ECC_CONTROL_OFS, 32'hfffffffe);
      rchk(`ECC_PARITY_OFS, good[15:0], "clear bit zero");
      wr(`ECC_CONTROL_OFS, 32'h1);
      rchk(`ECC_PARITY_OFS, 32'h0, "cleared parity");
      rchk(`ECC_INVERTED_PARITY_OFS, 32'h0, "cleared inverted");
   endtask
   task automatic t_single8;
      wr(`ECC_MODE_OFS, 32'h0);
      nand_flash_model_inst.load(16'h1357);
      good = calc(512, 9, 1'h0);
      nand_flash_model_inst.mem[300][5] ^= 1'b1;
      wr(`ECC_CONTROL_OFS, 32'h1);
      nand_flash_model_inst.send(528, 1'h0, 3);
      wr(`ECC_STORED_CODE_OFS, good);
      rchk(`ECC_STATUS_OFS, 32'h1, "single status");
      rchk(`ECC_PARITY_OFS, {16'h0, 12'd300, 4'd5}, "single address");
      rchk(`ECC_INT_STATUS_OFS, 32'h3, "event bits");
      irq_chk(1'h0);
      wr(`ECC_INT_MASK_OFS, 32'h2);
      irq_chk(1'h1);
      wr(`ECC_INT_MASK_OFS, 32'h0);
      irq_chk(1'h0);
      wr(`ECC_INT_MASK_OFS, 32'h3);
      wr(`ECC_INT_STATUS_OFS, 32'h3);
      irq_chk(1'h0);
      rchk(`ECC_INT_STATUS_OFS, 32'h0, "events cleared");
   endtask
   task automatic t_codebyte;
      nand_flash_model_inst.load(16'h2468);
      good = calc(512, 9, 1'h0);
      wr(`ECC_CONTROL_OFS, 32'h1);
      nand_flash_model_inst.send(528, 1'h0, 0);
      wr(`ECC_STORED_CODE_OFS, good ^ 32'h00000040);
      rchk(`ECC_STATUS_OFS, 32'h3, "code byte status");
      rd(`ECC_PARITY_OFS, d);
      rd(`ECC_INVERTED_PARITY_OFS, e);
      chk((d | e) & 32'hffff, 32'h40, "code byte position");
   endtask
   task automatic t_multi;
      nand_flash_model_inst.load(16'h0f0f);
      good = calc(512, 9, 1'h0);
      nand_flash_model_inst.mem[10][1] ^= 1'b1;
      nand_flash_model_inst.mem[200][6] ^= 1'b1;
      wr(`ECC_CONTROL_OFS, 32'h1);
      nand_flash_model_inst.send(528, 1'h0, 0);
      wr(`ECC_STORED_CODE_OFS, good);
      rchk(`ECC_STATUS_OFS, 32'h5, "multiple status");
   endtask
   // 16-bit part: clean page, then last main word broken plus a spare word
   task automatic t_wide;
      wr(`ECC_MODE_OFS, 32'h1);
      wr(`ECC_WIDTH_OFS, 32'h1);
      nand_flash_model_inst.load(16'hc3a5);
      good = calc(1024, 10, 1'h1);
      wr(`ECC_CONTROL_OFS, 32'h1);
      nand_flash_model_inst.send(1056, 1'h1, 0);
      wr(`ECC_STORED_CODE_OFS, good);
      rchk(`ECC_STATUS_OFS, 32'h0, "clean status");
      nand_flash_model_inst.mem[1023][15] ^= 1'b1;
      nand_flash_model_inst.mem[1040][0] ^= 1'b1;
      wr(`ECC_CONTROL_OFS, 32'h1);
      nand_flash_model_inst.send(1056, 1'h1, 0);
      wr(`ECC_STORED_CODE_OFS, good);
      rchk(`ECC_STATUS_OFS, 32'h1, "wide status");
      rchk(`ECC_PARITY_OFS, {16'h0, 12'd1023, 4'd15}, "wide address");
   endtask

   // ******
   // sequence and verdict
   // ******
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'h0;
      t_reset;
      t_mode;
      t_sizes;
      t_single8;
      t_codebyte;
      t_multi;
      t_wide;
      conclude;
   end
   // run needs about 13000 cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         conclude;
      end
   end
endmodule // testbench
